/* File: logic/power_down_clock_select.sv */
/*
  Power-down mode selection, clock-select and module standby control.
  Assumes the core pulses SLEEP_EXEC_I for one cycle per sleep instruction
  and WAKE_I for one cycle when an interrupt ends a halt state.
*/
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "pdcs_defines.svh"
module power_down_clock_select #(
  parameter logic [2:0] DIV_SEL4 = 3'h1,
  parameter logic [2:0] DIV_SEL5 = 3'h2,
  parameter logic [2:0] DIV_SEL6 = 3'h3,
  parameter logic [2:0] DIV_SEL7 = 3'h4
) (
  // Clock and reset
  input  wire logic       REF_CLK_I,
  input  wire logic       ARST_N_I,
  // Register port
  input  wire logic [3:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // Core events
  input  wire logic       SLEEP_EXEC_I,
  input  wire logic       WAKE_I,
  input  wire logic       WDT_INT_OSC_I,
  // Clock tree
  output logic      [2:0] ACT_DIV_LOG2_O,
  output logic            SUB_DIV8_O,
  output logic            USE_SUB_CLK_O,
  output logic            USE_ONCHIP_OSC_O,
  output logic            CPU_HALT_O,
  output logic      [2:0] MODE_O,
  // Peripheral standby
  output logic            TWO_WIRE_STBY_O,
  output logic            SERIAL_ONE_STBY_O,
  output logic            ADC_STBY_O,
  output logic            WDT_STBY_O,
  output logic            TIMER_V_STBY_O,
  output logic            RTC_STBY_O
);
  logic [7:0]  sys_one_ff;
  logic [7:0]  pwr_mode_ff;
  logic [7:0]  stby_one_ff;
  logic [2:0]  act_cur_ff;
  logic [1:0]  sub_cur_ff;
  logic [17:0] wait_cnt_ff;
  logic        wait_to_sub_ff;
  pdcs_pkg::mode_type mode_ff;
  pdcs_pkg::mode_type nxt_mode;
  pdcs_pkg::mode_type wake_mode;

  function automatic logic [17:0] wait_count(input logic [2:0] sel);
    case (sel)
      3'h0: wait_count = `WAIT_0;
      3'h1: wait_count = `WAIT_1;
      3'h2: wait_count = `WAIT_2;
      3'h3: wait_count = `WAIT_3;
      3'h4: wait_count = `WAIT_4;
      3'h5: wait_count = `WAIT_5;
      3'h6: wait_count = `WAIT_6;
      default: wait_count = `WAIT_7;
    endcase
  endfunction

  function automatic logic [2:0] act_div(input logic [2:0] sel);
    case (sel)
      3'h4: act_div = DIV_SEL4;
      3'h5: act_div = DIV_SEL5;
      3'h6: act_div = DIV_SEL6;
      3'h7: act_div = DIV_SEL7;
      default: act_div = 3'h0;
    endcase
  endfunction

  wire wr_sys  = WR_I && (ADDR_I == `ADDR_SYS_CTRL_ONE);
  wire wr_pwr  = WR_I && (ADDR_I == `ADDR_PWR_MODE);
  wire wr_stby = WR_I && (ADDR_I == `ADDR_STBY_ONE);
  wire sby_sel   = sys_one_ff[`SBY_SEL_BIT];
  wire submode   = pwr_mode_ff[`SUBMODE_BIT];
  wire low_speed = pwr_mode_ff[`LOW_SPEED_BIT];
  wire direct_go = pwr_mode_ff[`DIRECT_BIT];
  wire [2:0] wait_sel = sys_one_ff[`WAIT_SEL_LSB +: 3];
  wire [2:0] act_sel  = pwr_mode_ff[`ACT_LSB +: 3];
  wire [1:0] sub_sel  = pwr_mode_ff[`SUB_LSB +: 2];
  wire in_active = (mode_ff == pdcs_pkg::ACTIVE_ST);
  wire in_subact = (mode_ff == pdcs_pkg::SUBACTIVE_ST);
  wire sleep_ok  = SLEEP_EXEC_I && (in_active || in_subact);
  wire from_low  = (mode_ff == pdcs_pkg::STANDBY_ST) ||
                   (mode_ff == pdcs_pkg::SUBSLEEP_ST) || in_subact;
  // Leaving a low-speed state to active runs the wait.
  wire go_wait   = from_low && !low_speed;
  wire [7:0] rd_mux = (ADDR_I == `ADDR_SYS_CTRL_ONE) ? sys_one_ff :
                      (ADDR_I == `ADDR_PWR_MODE)     ? pwr_mode_ff :
                      (ADDR_I == `ADDR_STBY_ONE)     ? stby_one_ff :
                                                       `RST_BYTE;

  always_comb begin
    nxt_mode = mode_ff;
    wake_mode = low_speed ? pdcs_pkg::SUBACTIVE_ST :
                (go_wait ? pdcs_pkg::WAIT_ST : pdcs_pkg::ACTIVE_ST);
    if (sleep_ok) begin
      if (direct_go) begin
        if (low_speed) begin
          nxt_mode = pdcs_pkg::SUBACTIVE_ST;
        end else if (in_subact) begin
          nxt_mode = pdcs_pkg::WAIT_ST;
        end else begin
          nxt_mode = pdcs_pkg::ACTIVE_ST;
        end
      end else if (sby_sel) begin
        nxt_mode = pdcs_pkg::STANDBY_ST;
      end else if (!submode) begin
        nxt_mode = pdcs_pkg::SLEEP_ST;
      end else if (!low_speed) begin
        nxt_mode = pdcs_pkg::SUBSLEEP_ST;
      end
    end else if (WAKE_I && !in_active && !in_subact &&
                 (mode_ff != pdcs_pkg::WAIT_ST)) begin
      nxt_mode = wake_mode;
    end else if ((mode_ff == pdcs_pkg::WAIT_ST) &&
                 (wait_cnt_ff == 18'h00001)) begin
      nxt_mode = pdcs_pkg::ACTIVE_ST;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sys_one_ff  <= `RST_BYTE;
      pwr_mode_ff <= `RST_BYTE;
      stby_one_ff <= `RST_BYTE;
    end else begin
      if (wr_sys) begin
        sys_one_ff <= WDATA_I;
      end
      if (wr_pwr) begin
        pwr_mode_ff <= WDATA_I;
      end
      if (wr_stby) begin
        stby_one_ff <= WDATA_I & `STBY_ONE_WMASK;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mode_ff     <= pdcs_pkg::ACTIVE_ST;
      act_cur_ff  <= 3'h0;
      sub_cur_ff  <= 2'h0;
      wait_cnt_ff <= 18'h00000;
      RDATA_O     <= `RST_BYTE;
    end else begin
      mode_ff <= nxt_mode;
      RDATA_O <= RD_I ? rd_mux : `RST_BYTE;
      if (sleep_ok) begin
        act_cur_ff <= act_sel;
        sub_cur_ff <= sub_sel;
      end
      if ((nxt_mode == pdcs_pkg::WAIT_ST) &&
          (mode_ff != pdcs_pkg::WAIT_ST)) begin
        wait_cnt_ff <= wait_count(wait_sel);
      end else if (wait_cnt_ff != 18'h00000) begin
        wait_cnt_ff <= wait_cnt_ff - 18'h00001;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ACT_DIV_LOG2_O    <= 3'h0;
      SUB_DIV8_O        <= 1'b1;
      USE_SUB_CLK_O     <= 1'b0;
      USE_ONCHIP_OSC_O  <= 1'b0;
      CPU_HALT_O        <= 1'b0;
      MODE_O            <= 3'h0;
      TWO_WIRE_STBY_O   <= 1'b0;
      SERIAL_ONE_STBY_O <= 1'b0;
      ADC_STBY_O        <= 1'b0;
      WDT_STBY_O        <= 1'b0;
      TIMER_V_STBY_O    <= 1'b0;
      RTC_STBY_O        <= 1'b0;
    end else begin
      ACT_DIV_LOG2_O   <= act_div(act_cur_ff);
      // Subclock divide, 1X gives over 2.
      SUB_DIV8_O       <= !sub_cur_ff[1];
      USE_SUB_CLK_O    <= in_subact || (mode_ff == pdcs_pkg::SUBSLEEP_ST);
      USE_ONCHIP_OSC_O <= (mode_ff == pdcs_pkg::WAIT_ST);
      CPU_HALT_O       <= !in_active && !in_subact;
      MODE_O           <= mode_ff;
      TWO_WIRE_STBY_O   <= stby_one_ff[`TWO_WIRE_BIT];
      SERIAL_ONE_STBY_O <= stby_one_ff[`SERIAL_ONE_BIT];
      ADC_STBY_O        <= stby_one_ff[`ADC_BIT];
      TIMER_V_STBY_O    <= stby_one_ff[`TIMER_V_BIT];
      RTC_STBY_O        <= stby_one_ff[`RTC_BIT];
      WDT_STBY_O        <= stby_one_ff[`WDT_BIT] && !WDT_INT_OSC_I;
    end
  end

  sequence wait_entry_s;
    (mode_ff != pdcs_pkg::WAIT_ST) ##1 (mode_ff == pdcs_pkg::WAIT_ST);
  endsequence

  AST_WAIT_LOAD: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I) wait_entry_s |->
      wait_cnt_ff == wait_count($past(wait_sel)))
    else $error("Wait count not loaded from select.");
  AST_STBY_TARGET: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I) sleep_ok && !direct_go && sby_sel |=>
      mode_ff == pdcs_pkg::STANDBY_ST)
    else $error("Standby not entered.");
  AST_SLEEP_TARGET: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I) sleep_ok && !direct_go && !sby_sel && !submode |=>
      mode_ff == pdcs_pkg::SLEEP_ST)
    else $error("Sleep not entered.");
  AST_PENDING_CLK: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I) !sleep_ok |=> $stable(act_cur_ff))
    else $error("Clock select changed without sleep.");
  AST_UNDIV: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I) !act_cur_ff[2] |=> ACT_DIV_LOG2_O == 3'h0)
    else $error("0XX not undivided.");
  AST_SUB_DIV: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I) sub_cur_ff == 2'h0 |=> SUB_DIV8_O)
    else $error("00 not divide by 8.");
  AST_RSVD: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I)
      !stby_one_ff[`RSVD_HI_BIT] && !stby_one_ff[`RSVD_LO_BIT])
    else $error("Reserved standby bit set.");
  AST_WDT: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I) WDT_INT_OSC_I |=> !WDT_STBY_O)
    else $error("Watchdog stopped on internal oscillator.");
  AST_OSC_WAIT: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I) wait_entry_s |=> USE_ONCHIP_OSC_O)
    else $error("On-chip oscillator not used in wait.");
  AST_MSTBY: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I) wr_stby ##1 1'b1 |=>
      ADC_STBY_O == $past(WDATA_I[`ADC_BIT], 2))
    else $error("A/D standby not following register.");
endmodule

/* File: logic/pdcs_defines.svh */
/*
  Register offsets, field positions, reset values and wait counts for the
  power-down and clock-select control block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef PDCS_DEFINES_SVH
`define PDCS_DEFINES_SVH
`define ADDR_SYS_CTRL_ONE   4'h0
`define ADDR_PWR_MODE       4'h1
`define ADDR_STBY_ONE       4'h2
`define RST_BYTE            8'h00
`define STBY_ONE_WMASK      8'h7B
`define WAIT_SEL_LSB        4
`define SBY_SEL_BIT         7
`define SUBMODE_BIT         7
`define LOW_SPEED_BIT       6
`define DIRECT_BIT          5
`define TWO_WIRE_BIT        6
`define SERIAL_ONE_BIT      5
`define ADC_BIT             4
`define WDT_BIT             3
`define TIMER_V_BIT         1
`define RTC_BIT             0
`define RSVD_HI_BIT         7
`define RSVD_LO_BIT         2
`define ACT_LSB             2
`define SUB_LSB             0
`define WAIT_0              18'h02000
`define WAIT_1              18'h04000
`define WAIT_2              18'h08000
`define WAIT_3              18'h10000
`define WAIT_4              18'h20000
`define WAIT_5              18'h00400
`define WAIT_6              18'h00080
`define WAIT_7              18'h00010
`endif

/* File: logic/pdcs_pkg.sv */
/*
  Types of the power-down and clock-select control block.
  Assumes nothing of its surroundings.
*/
package pdcs_pkg;
  typedef enum logic [2:0] {
    ACTIVE_ST    = 3'h0,
    WAIT_ST      = 3'h1,
    SLEEP_ST     = 3'h3,
    SUBSLEEP_ST  = 3'h2,
    SUBACTIVE_ST = 3'h6,
    STANDBY_ST   = 3'h7
  } mode_type;
endpackage

/* File: test/core_model.sv */
/*
  Model of the processor core: bench requests become one-cycle sleep
  and wake pulses. Assumes requests change just after a rising edge.
*/
`timescale 1ns/10ps
module core_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Bench requests
  input  wire logic sleep_req_i,
  input  wire logic wake_req_i,
  // Core events
  output logic      sleep_exec_o,
  output logic      wake_o
);
  // A held request yields one pulse, as one instruction would.
  logic sleep_ff;
  logic wake_ff;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sleep_ff <= 1'b0;
      wake_ff  <= 1'b0;
    end else begin
      sleep_ff <= sleep_req_i;
      wake_ff  <= wake_req_i;
    end
  end
  assign sleep_exec_o = sleep_req_i & ~sleep_ff;
  assign wake_o       = wake_req_i & ~wake_ff;
endmodule

/* File: test/tb_top.sv */
/*
  Self-checking bench of the power-down and clock-select block.
  Assumes the design and the core model are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  logic       clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic       sleep_req = 1'b0, wake_req = 1'b0, wdt_osc = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, v, r;
  logic       sleep_exec, wake, sub_div8, use_sub, use_osc, halt;
  logic [2:0] act_div, mode, cur = 3'h0;
  logic [5:0] stby;
  int         errors, checked, cycles;
  int         wait_tab[8] = '{8192, 16384, 32768, 65536, 131072,
                              1024, 128, 16};
  always #2 clk = ~clk;
  core_model i_core (.clk_i(clk), .arst_n_i(arst_n), .wake_o(wake),
    .sleep_req_i(sleep_req), .wake_req_i(wake_req),
    .sleep_exec_o(sleep_exec));
  power_down_clock_select i_dut (.REF_CLK_I(clk), .ARST_N_I(arst_n),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .SLEEP_EXEC_I(sleep_exec), .WAKE_I(wake), .WDT_INT_OSC_I(wdt_osc),
    .ACT_DIV_LOG2_O(act_div), .SUB_DIV8_O(sub_div8), .USE_SUB_CLK_O(use_sub),
    .USE_ONCHIP_OSC_O(use_osc), .CPU_HALT_O(halt), .MODE_O(mode),
    .TWO_WIRE_STBY_O(stby[5]), .SERIAL_ONE_STBY_O(stby[4]),
    .ADC_STBY_O(stby[3]), .WDT_STBY_O(stby[2]), .TIMER_V_STBY_O(stby[1]),
    .RTC_STBY_O(stby[0]));
  task automatic tally_and_finish;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Divide ratios assume the default parameter values 1 to 4.
  function automatic logic [2:0] exp_div(input logic [2:0] sel);
    exp_div = sel[2] ? {1'b0, sel[1:0]} + 3'h1 : 3'h0;
  endfunction
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pulse(input logic s);
    @(posedge clk);
    sleep_req <= s;
    wake_req  <= ~s;
    @(posedge clk);
    sleep_req <= 1'b0;
    wake_req  <= 1'b0;
  endtask
  // Selections written before the sleep must not move the divider yet.
  task automatic go(input logic [7:0] c0, input logic [7:0] p,
                    input logic [2:0] exp);
    wr_reg(4'h0, c0);
    wr_reg(4'h1, p);
    repeat (3) @(posedge clk);
    #1 chk(18'(act_div), 18'(cur));
    pulse(1'b1);
    cur = exp_div(p[4:2]);
    repeat (3) @(posedge clk);
    #1 chk(18'(mode), 18'(exp));
    chk(18'(act_div), 18'(cur));
  endtask
  task automatic wake_up(input int w);
    int n;
    n = 0;
    pulse(1'b0);
    repeat (2) @(posedge clk);
    #1 if (w > 0) chk(18'(use_osc), 18'h00001);
    while (mode !== 3'h0 && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
    // The mode output shows the wait for w cycles, one of them before the loop.
    chk(18'(n), 18'((w > 0) ? w - 1 : 0));
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(32'h90A0));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    wr_reg(4'h3, 8'hFF);
    for (int a = 0; a < 4; a++) begin
      rd_reg(a[3:0], r);
      chk(18'(r), 18'h00000);
    end
    chk(18'({sub_div8, mode}), 18'h00008);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      wdt_osc <= (i < 2) ? i[0] : 1'($urandom);
      v = (i < 2) ? 8'hFF : 8'($urandom);
      wr_reg(4'h2, v);
      repeat (3) @(posedge clk);
      #1 chk(18'(stby), 18'({v[6:4], v[3] & ~wdt_osc, v[1:0]}));
      rd_reg(4'h2, r);
      chk(18'(r), 18'(v & 8'h7B));
    end
    $display("standby test done");
    go(8'h00, 8'h00, pdcs_pkg::SLEEP_ST);
    chk(18'(halt), 18'h00001);
    wake_up(0);
    go(8'h70, 8'h80, pdcs_pkg::SUBSLEEP_ST);
    wake_up(16);
    go(8'h70, 8'hC0, pdcs_pkg::ACTIVE_ST);
    go(8'h70, 8'h40, pdcs_pkg::SLEEP_ST);
    // Low-speed set: the interrupt returns to subactive.
    pulse(1'b0);
    repeat (3) @(posedge clk);
    #1 chk(18'(mode), 18'(pdcs_pkg::SUBACTIVE_ST));
    go(8'h70, 8'h60, pdcs_pkg::SUBACTIVE_ST);
    chk(18'({use_sub, sub_div8}), 18'h00003);
    go(8'h70, 8'h62, pdcs_pkg::SUBACTIVE_ST);
    chk(18'(sub_div8), 18'h00000);
    go(8'h70, 8'h20, pdcs_pkg::WAIT_ST);
    repeat (20) @(posedge clk);
    #1 chk(18'(mode), 18'(pdcs_pkg::ACTIVE_ST));
    for (int s = 5; s < 8; s++) begin
      go({1'b1, 3'(s), 4'h0}, 8'h00, pdcs_pkg::STANDBY_ST);
      wake_up(wait_tab[s]);
    end
    $display("mode test done");
    for (int s = 0; s < 8; s++)
      go(8'h00, {3'b001, 3'(s), 2'b00}, pdcs_pkg::ACTIVE_ST);
    $display("divider test done");
    tally_and_finish();
  end
endmodule
